// File: gcs_switch.sv
// Glitchless two-input clock switch with its APB control register.
// Assumes the source clocks are far slower than pclk; they are sampled,
// so the output is a pclk-registered replica of the chosen source.
// Functional notes
// - Exactly one source reaches the output; changes never glitch it.
// - Config bits 27:26 and select bits 25:24 choose A, C or ground.
// - Config field powers up at three; normally only select changes.
// - A select change starts the switch; one last full current pulse.
// - Output low until second desired rise, then desired clock.
// - No current rise by seventh desired rise: low until ninth.
// - Rise but no fall by fifteenth: low until seventeenth.
// - Power-up selects the C path.
// - Dividers are not glitch-free; change frequency by switching sources.
// - RC oscillator always runs; no disable control exists.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gcs_switch
    import gcs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_clock_a,
    input wire logic global_clock_c,
    output logic mux_clock_output,
    output logic [31:0] path_control,
    output logic switch_busy
);
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic a1_q, a2_q, a3_q, c1_q, c2_q, c3_q;
    gcs_src_t req_src;
    gcs_src_t req1_q, req2_q;
    gcs_state_t state_q, state_d;
    gcs_src_t active_q, active_d, target_q, target_d;
    logic [4:0] dcnt_q, dcnt_d;
    logic [1:0] lcnt_q, lcnt_d;
    logic out_q, out_d;
    logic to_rise_q, to_rise_d, to_fall_q, to_fall_d;
    logic cur_rise, cur_fall, des_rise, setup, access;
    logic [31:0] status;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign pslverr = err_q & access;
    assign path_control = ctrl_q;
    assign mux_clock_output = out_q;
    assign switch_busy = (state_q != GCS_RUN);

    always_comb begin
        status = 32'h0;
        status[GCS_ST_BUSY] = switch_busy;
        status[GCS_ST_ACT_LO +: 2] = active_q;
        status[GCS_ST_TGT_LO +: 2] = target_q;
        status[GCS_ST_TO_RISE] = to_rise_q;
        status[GCS_ST_TO_FALL] = to_fall_q;
    end

    // Read data and error latched in setup so the answer comes from flops
    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = rdata_q;
        err_d = err_q;
        if (setup) begin
            err_d = (paddr != GCS_CTRL_OFF) && (paddr != GCS_STAT_OFF);
            rdata_d = (paddr == GCS_CTRL_OFF) ? ctrl_q : ((paddr == GCS_STAT_OFF) ? status : 32'h0);
        end
        if (access && pwrite && (paddr == GCS_CTRL_OFF)) begin
            ctrl_d = pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= GCS_CTRL_RESET;
            rdata_q <= 32'h0;
            err_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // Path bits beyond the mux fields leave only on path_control and on CTRL reads; no RC enable
    // bit is decoded here since the RC source cannot be stopped.
    // Dividers live outside; frequency changes go through this switch.
    assign req_src = gcs_decode(ctrl_q[GCS_CFG_HI:GCS_CFG_LO], ctrl_q[GCS_SEL_HI:GCS_SEL_LO]);

    // Clock samples: stage 1 feeds stage 2 only; edges use stages 2 and 3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a1_q <= 1'b0;
            a2_q <= 1'b0;
            a3_q <= 1'b0;
            c1_q <= 1'b0;
            c2_q <= 1'b0;
            c3_q <= 1'b0;
            req1_q <= GCS_SRC_C;
            req2_q <= GCS_SRC_C;
        end else begin
            a1_q <= global_clock_a;
            a2_q <= a1_q;
            a3_q <= a2_q;
            c1_q <= global_clock_c;
            c2_q <= c1_q;
            c3_q <= c2_q;
            req1_q <= req_src;
            req2_q <= req1_q;
        end
    end

    assign cur_rise = gcs_rise(active_q, a2_q, a3_q, c2_q, c3_q);
    assign cur_fall = gcs_rise(active_q, ~a2_q, ~a3_q, ~c2_q, ~c3_q);
    assign des_rise = gcs_rise(target_q, a2_q, a3_q, c2_q, c3_q);

    always_comb begin
        state_d = state_q;
        active_d = active_q;
        target_d = target_q;
        dcnt_d = dcnt_q;
        lcnt_d = lcnt_q;
        to_rise_d = to_rise_q;
        to_fall_d = to_fall_q;
        out_d = 1'b0;
        unique case (state_q)
            GCS_RUN: begin
                out_d = gcs_level(active_q, a2_q, c2_q);
                if (req2_q != active_q) begin
                    state_d = GCS_WAIT_RISE;
                    target_d = req2_q;
                    dcnt_d = 5'h0;
                    to_rise_d = 1'b0;
                    to_fall_d = 1'b0;
                end
            end
            GCS_WAIT_RISE: begin
                out_d = gcs_level(active_q, a2_q, c2_q);
                if (des_rise) begin
                    dcnt_d = dcnt_q + 5'h1;
                end
                if (cur_rise) begin
                    state_d = GCS_WAIT_FALL;
                end else if (des_rise && (dcnt_q == GCS_TO_RISE_EDGES - 5'h1)) begin
                    state_d = GCS_LOW;
                    lcnt_d = 2'h0;
                    to_rise_d = 1'b1;
                    out_d = 1'b0;
                end
            end
            GCS_WAIT_FALL: begin
                out_d = gcs_level(active_q, a2_q, c2_q);
                if (des_rise) begin
                    dcnt_d = dcnt_q + 5'h1;
                end
                if (cur_fall) begin
                    state_d = GCS_LOW;
                    lcnt_d = 2'h0;
                    out_d = 1'b0;
                end else if (des_rise && (dcnt_q == GCS_TO_FALL_EDGES - 5'h1)) begin
                    state_d = GCS_LOW;
                    lcnt_d = 2'h0;
                    to_fall_d = 1'b1;
                    out_d = 1'b0;
                end
            end
            GCS_LOW: begin
                if (des_rise) begin
                    lcnt_d = lcnt_q + 2'h1;
                    if (lcnt_q == GCS_LOW_EDGES - 2'h1) begin
                        state_d = GCS_RUN;
                        active_d = target_q;
                        out_d = gcs_level(target_q, a2_q, c2_q);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= GCS_RUN;
            active_q <= GCS_SRC_C;
            target_q <= GCS_SRC_C;
            dcnt_q <= 5'h0;
            lcnt_q <= 2'h0;
            out_q <= 1'b0;
            to_rise_q <= 1'b0;
            to_fall_q <= 1'b0;
        end else begin
            state_q <= state_d;
            active_q <= active_d;
            target_q <= target_d;
            dcnt_q <= dcnt_d;
            lcnt_q <= lcnt_d;
            out_q <= out_d;
            to_rise_q <= to_rise_d;
            to_fall_q <= to_fall_d;
        end
    end

    property p_run_follows;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_RUN) |=> (out_q == $past(gcs_level(active_q, a2_q, c2_q)));
    endproperty
    a_run_follows: assert property (p_run_follows) else $error("Output not following source");

    property p_decode;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_q[GCS_CFG_HI:GCS_CFG_LO] == 2'h3 && ctrl_q[GCS_SEL_HI:GCS_SEL_LO] == 2'h0)
            |=> ##1 (req2_q == GCS_SRC_A);
    endproperty
    a_decode: assert property (p_decode) else $error("Select decode wrong");

    property p_reset_vals;
        @(posedge pclk) !presetn |-> (ctrl_q == GCS_CTRL_RESET) && (active_q == GCS_SRC_C);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("Reset values wrong");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_RUN && req2_q != active_q) |=> (state_q == GCS_WAIT_RISE) && (target_q == $past(req2_q));
    endproperty
    a_start: assert property (p_start) else $error("Switch did not start");

    property p_low_out;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_LOW && state_d == GCS_LOW) |=> !out_q;
    endproperty
    a_low_out: assert property (p_low_out) else $error("Output high while held low");

    property p_low_exit;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_LOW && des_rise && lcnt_q == 2'h1) |=> (state_q == GCS_RUN) && (active_q == $past(target_q));
    endproperty
    a_low_exit: assert property (p_low_exit) else $error("Late or wrong handover");

    property p_rise_to;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_WAIT_RISE && des_rise && !cur_rise && dcnt_q == 5'h6) |=> (state_q == GCS_LOW) && to_rise_q;
    endproperty
    a_rise_to: assert property (p_rise_to) else $error("Rise timeout missed");

    property p_fall_to;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_WAIT_FALL && des_rise && !cur_fall && dcnt_q == 5'he) |=> (state_q == GCS_LOW) && to_fall_q;
    endproperty
    a_fall_to: assert property (p_fall_to) else $error("Fall timeout missed");

    property p_sync;
        @(posedge pclk) disable iff (!presetn)
        $changed(req_src) |-> ##1 (req2_q != req_src) ##1 (req2_q == $past(req_src, 2));
    endproperty
    a_sync: assert property (p_sync) else $error("Request not two-stage synchronised");

    property p_rise_wait;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_WAIT_RISE) |-> (dcnt_q < GCS_TO_RISE_EDGES);
    endproperty
    a_rise_wait: assert property (p_rise_wait) else $error("Rise window overran");

    property p_fall_wait;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_WAIT_FALL) |-> (dcnt_q < GCS_TO_FALL_EDGES);
    endproperty
    a_fall_wait: assert property (p_fall_wait) else $error("Fall window overran");

    property p_low_count;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_LOW) |-> (lcnt_q < GCS_LOW_EDGES);
    endproperty
    a_low_count: assert property (p_low_count) else $error("Low phase overran");

    // Last current pulse passes untouched until its falling edge
    property p_fall_hold;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_WAIT_FALL && !cur_fall && !(des_rise && dcnt_q == GCS_TO_FALL_EDGES - 5'h1))
            |=> (out_q == $past(gcs_level(active_q, a2_q, c2_q)));
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("Final pulse cut short");

    property p_flags_clear;
        @(posedge pclk) disable iff (!presetn)
        (state_q == GCS_RUN && req2_q != active_q) |=> !to_rise_q && !to_fall_q;
    endproperty
    a_flags_clear: assert property (p_flags_clear) else $error("Timeout flags not cleared");

    c_clean: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == GCS_WAIT_FALL ##1 state_q == GCS_LOW ##[1:200] state_q == GCS_RUN);
    c_rise_to: cover property (@(posedge pclk) disable iff (!presetn) $rose(to_rise_q));
    c_fall_to: cover property (@(posedge pclk) disable iff (!presetn) $rose(to_fall_q));
    c_gnd: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == GCS_RUN && active_q == GCS_SRC_GND);
endmodule
`default_nettype wire

// File: gcs_pkg.sv
// Constants, types and decode helpers for the glitchless clock switch.
// Assumes a single 10 MHz pclk domain and an APB register port.
package gcs_pkg;
    localparam int GCS_PCLK_HZ = 10000000;
    localparam logic [7:0] GCS_CTRL_OFF = 8'h00;
    localparam logic [7:0] GCS_STAT_OFF = 8'h04;
    localparam logic [31:0] GCS_CTRL_RESET = 32'h0d800000;
    localparam int GCS_CFG_HI = 27;
    localparam int GCS_CFG_LO = 26;
    localparam int GCS_SEL_HI = 25;
    localparam int GCS_SEL_LO = 24;
    localparam logic [4:0] GCS_TO_RISE_EDGES = 5'h07;
    localparam logic [4:0] GCS_TO_FALL_EDGES = 5'h0f;
    localparam logic [1:0] GCS_LOW_EDGES = 2'h2;
    localparam int GCS_ST_BUSY = 0;
    localparam int GCS_ST_ACT_LO = 1;
    localparam int GCS_ST_TGT_LO = 3;
    localparam int GCS_ST_TO_RISE = 5;
    localparam int GCS_ST_TO_FALL = 6;

    typedef enum logic [1:0] {
        GCS_SRC_A = 2'h0,
        GCS_SRC_C = 2'h1,
        GCS_SRC_GND = 2'h2,
        GCS_SRC_RSVD = 2'h3
    } gcs_src_t;

    typedef enum logic [1:0] {
        GCS_RUN = 2'h0,
        GCS_WAIT_RISE = 2'h1,
        GCS_WAIT_FALL = 2'h3,
        GCS_LOW = 2'h2
    } gcs_state_t;

    function automatic gcs_src_t gcs_decode(input logic [1:0] cfg, input logic [1:0] sel);
        gcs_src_t s;
        s = GCS_SRC_RSVD;
        unique case (cfg)
            2'h0: s = sel[0] ? GCS_SRC_C : GCS_SRC_A;
            2'h1: s = sel[0] ? GCS_SRC_RSVD : GCS_SRC_A;
            2'h2: s = sel[0] ? GCS_SRC_RSVD : GCS_SRC_C;
            2'h3: begin
                unique case (sel)
                    2'h0: s = GCS_SRC_A;
                    2'h1: s = GCS_SRC_C;
                    2'h2: s = GCS_SRC_RSVD;
                    2'h3: s = GCS_SRC_GND;
                endcase
            end
        endcase
        return s;
    endfunction

    // Reserved codes are treated as ground: output stays low
    function automatic logic gcs_level(input gcs_src_t s, input logic a, input logic c);
        return (s == GCS_SRC_A) ? a : ((s == GCS_SRC_C) ? c : 1'b0);
    endfunction

    // A stopped source has no edges; ground ticks every pclk so switches complete
    function automatic logic gcs_rise(input gcs_src_t s, input logic a, input logic a_old,
                                      input logic c, input logic c_old);
        return (s == GCS_SRC_A) ? (a & ~a_old) : ((s == GCS_SRC_C) ? (c & ~c_old) : 1'b1);
    endfunction
endpackage

// File: gcs_clk_src.sv
// Partner model: the two source clocks that feed the switch.
// Free running; a stopped clock parks at the requested level.
`timescale 1ns/1ps
`default_nettype none
module gcs_clk_src #(
    parameter int HALF_A = 300,
    parameter int HALF_C = 500
) (
    output logic global_clock_a,
    output logic global_clock_c,
    input wire logic run_a,
    input wire logic run_c,
    input wire logic park_a,
    input wire logic park_c
);
    // Odd offsets keep source edges away from pclk edges
    initial begin
        global_clock_a = 1'b0;
        #37;
        forever begin
            #(HALF_A);
            if (run_a || global_clock_a !== park_a)
                global_clock_a = ~global_clock_a;
        end
    end
    initial begin
        global_clock_c = 1'b0;
        #71;
        forever begin
            #(HALF_C);
            if (run_c || global_clock_c !== park_c)
                global_clock_c = ~global_clock_c;
        end
    end
endmodule
`default_nettype wire

// File: gcs_switch_test.sv
// Self-checking bench for the glitchless clock switch.
// Assumes gcs_clk_src sources far slower than the 10 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module gcs_switch_test;
    import gcs_pkg::*;
    logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, path_control, rd;
    logic pready, pslverr, global_clock_a, global_clock_c, mux_clock_output, switch_busy, er;
    logic run_a = 1'b1, run_c = 1'b1, park_a = 1'b0, park_c = 1'b0, pa, pc, pb, po;
    int err_count = 0, checks = 0, cyc = 0, na = 0, nc = 0, run_len = 0;
    logic [31:0] rng = 32'h00010b4a;

    gcs_switch gcs_switch_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .global_clock_a(global_clock_a), .global_clock_c(global_clock_c),
        .mux_clock_output(mux_clock_output), .path_control(path_control), .switch_busy(switch_busy));
    gcs_clk_src gcs_clk_src_i (.global_clock_a(global_clock_a), .global_clock_c(global_clock_c),
        .run_a(run_a), .run_c(run_c), .park_a(park_a), .park_c(park_c));

    initial begin
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Rise counts run only while a switch is in progress
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        pa <= global_clock_a;
        pc <= global_clock_c;
        pb <= switch_busy;
        po <= mux_clock_output;
        if (switch_busy === 1'b1 && pb !== 1'b1) begin
            na <= 0;
            nc <= 0;
        end else if (switch_busy === 1'b1) begin
            na <= na + int'(global_clock_a & ~pa);
            nc <= nc + int'(global_clock_c & ~pc);
        end
        run_len <= (mux_clock_output === po) ? run_len + 1 : 1;
        if (cyc > 25 && mux_clock_output !== po && run_len < 2)
            chk(32'h0, 32'h1, "short output pulse");
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Source code: 0 A, 1 C, 2 ground, 3 reserved
    function automatic logic [1:0] exp_src(input logic [1:0] cfg, input logic [1:0] sel);
        case (cfg)
            2'h0: return sel[0] ? 2'h1 : 2'h0;
            2'h1: return sel[0] ? 2'h3 : 2'h0;
            2'h2: return sel[0] ? 2'h3 : 2'h1;
            default: return (sel == 2'h0) ? 2'h0 : (sel == 2'h1) ? 2'h1 : (sel == 2'h3) ? 2'h2 : 2'h3;
        endcase
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Waits for the handover to end, then leaves the status word in rd
    task automatic fin();
        int n;
        n = 0;
        while (switch_busy !== 1'b0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, switch_busy}, 32'h0, "switch stuck");
        apb(1'b0, GCS_STAT_OFF, 32'h0);
    endtask

    initial begin
        logic [31:0] v, cur;
        logic [1:0] e, s;
        int n;
        // Falling edge at time zero so the design's async reset really fires
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, GCS_CTRL_OFF, 32'h0);
        chk({30'h0, rd[27:26]}, 32'h3, "cfg reset");
        chk(rd, GCS_CTRL_RESET, "ctrl reset");
        chk(path_control, GCS_CTRL_RESET, "path reset");
        apb(1'b0, GCS_STAT_OFF, 32'h0);
        chk({30'h0, rd[2:1]}, 32'h1, "reset source");
        apb(1'b1, GCS_STAT_OFF, 32'hffffffff);
        chk({31'h0, er}, 32'h0, "status write");
        apb(1'b0, 8'h08, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
        $display("test reset done");
        cur = GCS_CTRL_RESET;
        for (int i = 0; i < 16; i++) begin
            rng = xs(rng);
            v = rng;
            e = exp_src(v[27:26], v[25:24]);
            s = exp_src(cur[27:26], cur[25:24]);
            if (e == 2'h3)
                continue;
            // Path bits outside 27:24 change first with the mux fields held; no switch may start
            apb(1'b1, GCS_CTRL_OFF, {v[31:28], cur[27:24], v[23:0]});
            repeat (3) @(posedge pclk);
            chk({31'h0, switch_busy}, 32'h0, "path write switched");
            chk(path_control, {v[31:28], cur[27:24], v[23:0]}, "path bits");
            apb(1'b1, GCS_CTRL_OFF, v);
            repeat (3) @(posedge pclk);
            fin();
            chk({30'h0, rd[2:1]}, {30'h0, e}, "decode");
            chk(path_control, v, "ctrl stored");
            if (s != e && s != 2'h2 && e != 2'h2)
                chk({31'h0, rd[6:5] == 2'h0 && (e ? nc : na) <= 6}, 32'h1, "handover");
            cur = v;
        end
        $display("test random done");
        apb(1'b1, GCS_CTRL_OFF, 32'h0c000000);
        repeat (3) @(posedge pclk);
        fin();
        run_a <= 1'b0;
        apb(1'b1, GCS_CTRL_OFF, 32'h0d000000);
        repeat (3) @(posedge pclk);
        fin();
        chk({26'h0, rd[6:1]}, 32'h15, "stall low status");
        chk({31'h0, nc >= 8 && nc <= 10}, 32'h1, "stall low length");
        // Current clock parked low first, so its one rise falls inside the switch window
        run_a <= 1'b1;
        run_c <= 1'b0;
        repeat (20) @(posedge pclk);
        apb(1'b1, GCS_CTRL_OFF, 32'h0c000000);
        n = 0;
        while (switch_busy !== 1'b1 && n < 30) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, switch_busy}, 32'h1, "switch not started");
        park_c <= 1'b1;
        fin();
        chk({26'h0, rd[6:1]}, 32'h20, "stall high status");
        chk({31'h0, na >= 16 && na <= 18}, 32'h1, "stall high length");
        run_c <= 1'b1;
        $display("test stall done");
        summarize();
    end
endmodule
`default_nettype wire
